// ### hw/tpan_pkg.sv
// Package of constants and carrier types for the twisted-pair negotiation pulse link.
// Assumes a 100 MHz system clock; every time below is converted to cycles of that clock.
//
// What this block does
// - Code word bits sent D0 first, D15 last.
// - Only defined selector codes are ever transmitted.
// - Advertise only abilities the device supports.
// - Acknowledge after three consistent bursts, no next page.
// - With next page, save word before acknowledge.
// - Send six to eight acknowledged words, then stop.
// - No next-page ability: base word NP cleared.
// - Next-page able and willing: base NP set.
// - After completion transmit only the chosen PMA.
// - Partner capable after 6..17 well-spaced pulses.
// - Discard data of incomplete first burst.
// - First pulse of each burst is clock.
// - Clock pulse restarts both data detect timers.
// - Pulse between min and max records one.
// - Pulse after max is clock; bit zero.
// - After completion receive feeds chosen PMA only.
// - During negotiation receive feeds pulse receivers.
// - Receive produces ability, acknowledge, consistency matches.
// - Burst has 17 clock and 16 data positions.
// - Clock pulses 125 us apart within tolerance.
// - One bit pulse 62.5 us after clock.
// - Bursts start 16 ms apart.
package tpan_pkg;

	//****************************************************************
	// Clock and timing.
	//****************************************************************
	localparam int CLK_MHZ             = 100;          // System clock rate in MHz.
	localparam int CLK_PULSE_NS        = 125000;       // Clock pulse spacing in ns.
	localparam int DATA_PULSE_NS       = 62500;        // Data pulse offset in ns.
	localparam int BURST_US            = 16000;        // Burst start spacing in us.
	localparam int PULSE_WIDTH_NS      = 100;          // Width of one emitted pulse in ns.
	localparam int DET_MIN_NS          = 15000;        // data_detect_min_timer in ns.
	localparam int DET_MAX_NS          = 78000;        // data_detect_max_timer in ns.
	localparam int FLP_MIN_NS          = 5000;         // flp_test_min_timer in ns.
	localparam int FLP_MAX_NS          = 165000;       // flp_test_max_timer in ns.
	// Cycle counts: least times round up, longest times round down.
	localparam int CLK_PULSE_CYC  = CLK_PULSE_NS * CLK_MHZ / 1000;
	localparam int DATA_PULSE_CYC = DATA_PULSE_NS * CLK_MHZ / 1000;
	localparam int BURST_CYC      = BURST_US * CLK_MHZ;
	localparam int PULSE_CYC      = (PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
	localparam int DET_MIN_CYC    = (DET_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int DET_MAX_CYC    = DET_MAX_NS * CLK_MHZ / 1000;
	localparam int FLP_MIN_CYC    = (FLP_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int FLP_MAX_CYC    = FLP_MAX_NS * CLK_MHZ / 1000;

	//****************************************************************
	// Word layout and counts.
	//****************************************************************
	localparam int WORD_BITS      = 16;                // Bits of a link code word.
	localparam int CLK_POSITIONS  = 17;                // Clock positions per burst.
	localparam int CAP_MIN_PULSES = 6;                 // Least pulses to call partner capable.
	localparam int CAP_MAX_PULSES = 17;                // Most pulses counted for capability.
	localparam int CONSIST_BURSTS = 3;                 // Consistent bursts before acknowledge.
	localparam int ACK_WORDS      = 6;                 // Acknowledged words sent on completion.
	localparam int SEL_LSB        = 0;                 // Selector field position.
	localparam int SEL_W          = 5;                 // Selector field width.
	localparam int ABIL_LSB       = 5;                 // Technology ability field position.
	localparam int ABIL_W         = 8;                 // Technology ability field width.
	localparam int ACK_BIT        = 14;                // Acknowledge bit position.
	localparam int NP_BIT         = 15;                // Next page bit position.
	localparam logic [4:0] SEL_CSMA = 5'h01;           // The one defined selector encoding.
	localparam int PMA_N          = 4;                 // Number of technology PMAs.

	// Match indications gathered as one carrier.
	typedef struct packed {
		logic ability;                             // Same ability word three times.
		logic acknowledge;                         // Same word with ack set twice, flagged at the next word.
		logic consistency;                         // Ack word equals matched ability word.
	} tpan_match_type;

endpackage : tpan_pkg

// ### hw/tpan_link.sv
// Fast-link-pulse transmitter, receiver and medium switches for negotiation.
// Assumes an asynchronous pulse input from the medium front end and an outside arbiter.
`timescale 1ns/1ns
module tpan_link
	import tpan_pkg::*;
(
	input  wire logic                 sys_clk,        // System clock, 100 MHz.
	input  wire logic                 rst,            // Asynchronous reset, active high.
	// Register bus.
	input  wire logic                 psel,           // Slave select.
	input  wire logic                 penable,        // Access phase.
	input  wire logic                 pwrite,         // Write when high.
	input  wire logic [7:0]           paddr,          // Byte address.
	input  wire logic [31:0]          pwdata,         // Write data.
	output logic      [31:0]          prdata,         // Read data.
	output logic                      pready,         // Always ready.
	output logic                      pslverr,        // Error on unmapped address.
	// Medium.
	input  wire logic                 mdi_pulse_in,   // Pulse detector output from medium.
	output logic                      mdi_pulse_out,  // Pulse to line driver.
	input  wire logic [PMA_N-1:0]     pma_tx,         // Transmit data of each PMA.
	output logic                      mdi_tx,         // Transmit towards the line.
	output logic [PMA_N-1:0]          pma_rx_en,      // Receive path to each PMA.
	output logic                      pulse_rx_en,    // Receive path to pulse receivers.
	// Negotiation status.
	output logic                      partner_able,   // Partner negotiation capable.
	output logic                      complete_ack,   // Acknowledged words are done.
	output tpan_match_type            match           // Match indications.
);

	//****************************************************************
	// Register map.
	//****************************************************************
	localparam logic [7:0] ADR_CTRL   = 8'h00;   // Enable, next page, hcd, done.
	localparam logic [7:0] ADR_ADV    = 8'h04;   // Advertised word.
	localparam logic [7:0] ADR_RX     = 8'h08;   // Last received word.
	localparam logic [7:0] ADR_SAVED  = 8'h0C;   // Saved received word.
	localparam logic [7:0] ADR_STAT   = 8'h10;   // Status.
	localparam logic [7:0] SUPPORTED  = 8'h0F;   // Abilities this device really supports.
	localparam logic       HAS_NP     = 1'b1;    // Device implements next pages.

	logic        en_ff;            // Negotiation running.
	logic        np_want_ff;       // Software wants to exchange next pages.
	logic        done_ff;          // Highest common technology chosen.
	logic [1:0]  hcd_ff;           // Index of the chosen PMA.
	logic [15:0] adv_ff;           // Advertised word as written.
	logic [15:0] saved_ff;         // Received word saved for next page.
	logic        saved_ok_ff;      // Saved word is current.

	wire wr = psel & penable & pwrite;
	wire rd_ok = (paddr == ADR_CTRL) | (paddr == ADR_ADV) | (paddr == ADR_RX)
		| (paddr == ADR_SAVED) | (paddr == ADR_STAT);

	// Single-cycle access phase; unmapped addresses answer an error.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~rd_ok;

	//****************************************************************
	// Transmit word composition.
	//****************************************************************
	logic        ack_ff;          // Acknowledge bit to send.
	wire  [15:0] tx_word;
	wire  [4:0]  tx_sel = (adv_ff[SEL_LSB +: SEL_W] == SEL_CSMA) ? adv_ff[SEL_LSB +: SEL_W]
		: SEL_CSMA;
	wire  [7:0]  tx_abil = adv_ff[ABIL_LSB +: ABIL_W] & SUPPORTED;
	wire         tx_np = HAS_NP & np_want_ff;
	assign tx_word = {tx_np, ack_ff, adv_ff[13], tx_abil, tx_sel};

	//****************************************************************
	// Burst generator.
	//****************************************************************
	logic [20:0] gap_ff;          // Cycles since this burst started.
	logic [5:0]  pos_ff;          // Pulse position within the burst, 0..33.
	logic [13:0] slot_ff;         // Cycles inside the current half-slot.
	logic [15:0] shift_ff;        // Word latched at burst start.
	logic [3:0]  sent_ack_ff;     // Words sent with acknowledge set after the acknowledge match.
	logic [7:0]  pw_ff;           // Remaining pulse width.
	logic        tx_stop;

	assign tx_stop = (sent_ack_ff >= 4'(ACK_WORDS)) | ~en_ff;
	wire burst_go = (gap_ff == 21'(BURST_CYC - 1)) & ~tx_stop;
	wire in_burst = (pos_ff != 6'd0);
	wire slot_end = (slot_ff == 14'(DATA_PULSE_CYC - 1));
	// Odd positions are clocks; even ones carry word bits, D0 first.
	wire [5:0] nxt_pos = pos_ff + 6'd1;
	wire fire = burst_go | (in_burst & slot_end & (nxt_pos <= 6'd33)
		& (nxt_pos[0] | shift_ff[0]));

	// One process walks the 33 positions and the 16 ms burst spacing.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gap_ff   <= 21'd0;
			pos_ff   <= 6'd0;
			slot_ff  <= 14'd0;
			shift_ff <= 16'h0000;
			pw_ff    <= 8'h00;
		end else begin
			gap_ff  <= burst_go ? 21'd0 : (gap_ff == 21'(BURST_CYC - 1) ? gap_ff : gap_ff + 21'd1);
			slot_ff <= (burst_go | slot_end) ? 14'd0 : slot_ff + 14'd1;
			if (burst_go) begin
				pos_ff   <= 6'd1;
				shift_ff <= tx_word;
			end else if (in_burst & slot_end) begin
				pos_ff <= (nxt_pos > 6'd33) ? 6'd0 : nxt_pos;
				// A data slot just passed: expose the next bit.
				if (~nxt_pos[0]) begin
					shift_ff <= shift_ff;
				end else if (nxt_pos != 6'd1) begin
					shift_ff <= {1'b0, shift_ff[15:1]};
				end
			end
			pw_ff <= fire ? 8'(PULSE_CYC) : (pw_ff != 8'h00 ? pw_ff - 8'h01 : 8'h00);
		end
	end

	//****************************************************************
	// Transmit switch.
	//****************************************************************
	// Pulse generator owns the line until a technology is chosen.
	assign mdi_pulse_out = ~done_ff & (pw_ff != 8'h00);
	assign mdi_tx = done_ff ? pma_tx[hcd_ff] : 1'b0;

	//****************************************************************
	// Receive switch.
	//****************************************************************
	assign pulse_rx_en = ~done_ff;
	// The 100 Mb/s link monitors (PMA 2 and 3) also listen while negotiating.
	genvar g;
	for (g = 0; g < PMA_N; g++) begin : g_rx
		assign pma_rx_en[g] = done_ff ? (hcd_ff == 2'(g)) : (g >= 2);
	end

	//****************************************************************
	// Pulse receiver.
	//****************************************************************
	logic [1:0]  sync_ff;          // Input synchroniser.
	logic        prev_ff;          // Last synchronised level.
	logic [14:0] since_ff;         // Cycles since last clock pulse.
	logic [14:0] any_ff;           // Cycles since any pulse.
	logic [4:0]  cnt_ff;           // Consecutive well-spaced pulses.
	logic        able_ff;          // Partner capable.
	logic        first_ff;         // Current burst is the one that found the partner.
	logic [4:0]  bit_ff;           // Data bit index.
	logic [15:0] rx_sh_ff;         // Word being assembled.
	logic [15:0] rx_ff;            // Last complete word.
	logic        new_ff;           // One-cycle: a word completed.
	logic        one_ff;           // A data pulse came in the current slot.
	logic        idle;

	wire pulse = sync_ff[1] & ~prev_ff;
	wire gap_ok = (any_ff >= 15'(FLP_MIN_CYC)) & (any_ff < 15'(FLP_MAX_CYC));
	assign idle = (since_ff >= 15'(FLP_MAX_CYC));
	// First pulse after idle is a clock; a late pulse is a clock too.
	wire is_data = pulse & ~idle & (since_ff > 15'(DET_MIN_CYC))
		& (since_ff < 15'(DET_MAX_CYC));
	wire is_clk = pulse & ~is_data;
	// A burst that timed out with all 16 bits gives a whole word.
	wire burst_end = idle & (since_ff == 15'(FLP_MAX_CYC)) & (bit_ff != 5'd0);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync_ff  <= 2'b00;
			prev_ff  <= 1'b0;
			since_ff <= 15'h7FFF;
			any_ff   <= 15'h7FFF;
		end else begin
			sync_ff  <= {sync_ff[0], mdi_pulse_in};
			prev_ff  <= sync_ff[1];
			since_ff <= is_clk ? 15'd0 : (idle ? since_ff : since_ff + 15'd1);
			any_ff   <= pulse ? 15'd0 : (any_ff == 15'h7FFF ? any_ff : any_ff + 15'd1);
		end
	end

	// Capability detection and bit assembly.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_ff   <= 5'd0;
			able_ff  <= 1'b0;
			first_ff <= 1'b0;
			bit_ff   <= 5'd0;
			rx_sh_ff <= 16'h0000;
			rx_ff    <= 16'h0000;
			new_ff   <= 1'b0;
			one_ff   <= 1'b0;
		end else begin
			new_ff <= 1'b0;
			if (pulse) begin
				cnt_ff <= gap_ok ? ((cnt_ff == 5'(CAP_MAX_PULSES)) ? cnt_ff : cnt_ff + 5'd1) : 5'd1;
				if (~able_ff & gap_ok & (cnt_ff + 5'd1 >= 5'(CAP_MIN_PULSES))) begin
					able_ff  <= 1'b1;
					first_ff <= 1'b1;
				end
			end
			if (is_clk & ~idle) begin
				// A clock closes the data slot before it; the bit is one only if a
				// data pulse came in that slot, so each slot gives exactly one bit.
				bit_ff   <= (bit_ff == 5'd16) ? bit_ff : bit_ff + 5'd1;
				rx_sh_ff <= {one_ff, rx_sh_ff[15:1]};
				one_ff   <= 1'b0;
			end else if (is_clk) begin
				bit_ff   <= 5'd0;
				rx_sh_ff <= 16'h0000;
				one_ff   <= 1'b0;
			end
			if (is_data) begin
				one_ff <= 1'b1;
			end
			if (burst_end) begin
				bit_ff <= 5'd0;
				first_ff <= 1'b0;
				// Short first burst's bits are dropped.
				if ((bit_ff == 5'd16) & able_ff & ~(first_ff & (cnt_ff < 5'(CAP_MAX_PULSES)))) begin
					rx_ff  <= rx_sh_ff;
					new_ff <= 1'b1;
				end
			end
		end
	end

	//****************************************************************
	// Match indications and acknowledge.
	//****************************************************************
	logic [1:0]  same_ff;          // Consecutive identical words minus one.
	logic [1:0]  asame_ff;         // Same, counting words with ack set.
	logic [15:0] abil_word_ff;     // Previous received word, updated at every new word.
	wire  [14:0] cmp_prev = rx_ff[14:0];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			same_ff      <= 2'd0;
			asame_ff     <= 2'd0;
			abil_word_ff <= 16'h0000;
			match        <= '0;
		end else if (new_ff) begin
			// Ack bit is ignored in the same_ff count; ability match also needs the newest two words equal in full.
			same_ff <= ({rx_ff[15], cmp_prev[13:0]} == {abil_word_ff[15], abil_word_ff[13:0]})
				? ((same_ff == 2'(CONSIST_BURSTS - 1)) ? same_ff : same_ff + 2'd1) : 2'd0;
			asame_ff <= (rx_ff[ACK_BIT] & (rx_ff == abil_word_ff))
				? ((asame_ff == 2'(CONSIST_BURSTS - 1)) ? asame_ff : asame_ff + 2'd1) : 2'd0;
			abil_word_ff      <= rx_ff;
			match.ability     <= (same_ff >= 2'(CONSIST_BURSTS - 2)) & (rx_ff == abil_word_ff);
			match.acknowledge <= (asame_ff >= 2'(CONSIST_BURSTS - 2));
			match.consistency <= match.ability
				& ({rx_ff[15], rx_ff[13:0]} == {abil_word_ff[15], abil_word_ff[13:0]});
		end
	end

	// Acknowledge after three consistent bursts, and with next pages only once saved.
	wire ack_ready = match.ability & (~tx_np | saved_ok_ff);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_ff      <= 1'b0;
			sent_ack_ff <= 4'd0;
			saved_ff    <= 16'h0000;
			saved_ok_ff <= 1'b0;
		end else begin
			if (match.ability & ~saved_ok_ff) begin
				saved_ff    <= rx_ff;
				saved_ok_ff <= 1'b1;
			end
			if (ack_ready) begin
				ack_ff <= 1'b1;
			end
			if (burst_go & ack_ff & match.acknowledge) begin
				sent_ack_ff <= sent_ack_ff + 4'd1;
			end
			if (~en_ff) begin
				ack_ff <= 1'b0;
				sent_ack_ff <= 4'd0;
				saved_ok_ff <= 1'b0;
			end
		end
	end

	assign partner_able = able_ff;
	assign complete_ack = (sent_ack_ff >= 4'(ACK_WORDS));

	//****************************************************************
	// Register writes and reads.
	//****************************************************************
	// Writes take effect at the access-phase edge; reads are from flip-flops below.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			en_ff      <= 1'b0;
			np_want_ff <= 1'b0;
			done_ff    <= 1'b0;
			hcd_ff     <= 2'd0;
			adv_ff     <= 16'h0021;
		end else if (wr & (paddr == ADR_CTRL)) begin
			en_ff      <= pwdata[0];
			np_want_ff <= pwdata[1];
			done_ff    <= pwdata[2];
			hcd_ff     <= pwdata[5:4];
		end else if (wr & (paddr == ADR_ADV)) begin
			adv_ff <= pwdata[15:0];
		end
	end

	wire [31:0] rd_mux =
		(paddr == ADR_CTRL)  ? {26'h0, hcd_ff, 1'b0, done_ff, np_want_ff, en_ff} :
		(paddr == ADR_ADV)   ? {16'h0, tx_word} :
		(paddr == ADR_RX)    ? {16'h0, rx_ff} :
		(paddr == ADR_SAVED) ? {16'h0, saved_ff} :
		(paddr == ADR_STAT)  ? {26'h0, complete_ack, match, ack_ff, able_ff} : 32'h0000_0000;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= rd_mux;
		end
	end

endmodule : tpan_link

// ### verification/tpan_link_props.sv
// Checker for the negotiation pulse link, watching only the top ports.
// Assumes the bind below attaches it to every tpan_link instance.
`timescale 1ns/1ns
module tpan_link_props
	import tpan_pkg::*;
(
	input wire logic             sys_clk,
	input wire logic             rst,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             mdi_pulse_in,
	input wire logic             mdi_pulse_out,
	input wire logic [PMA_N-1:0] pma_tx,
	input wire logic             mdi_tx,
	input wire logic [PMA_N-1:0] pma_rx_en,
	input wire logic             pulse_rx_en,
	input wire logic             partner_able
);
	//****************
	// Pulse counting.
	//****************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic       seen_ff;   // Line level one cycle back.
	logic [4:0] pcnt_ff;   // Pulses since reset, saturating.
	wire        pin_rise = mdi_pulse_in && !seen_ff;
	wire  [4:0] nxt_pcnt = (pin_rise && pcnt_ff != 5'h1F) ? pcnt_ff + 5'h01 : pcnt_ff;
	// An own count, so a wrong counter in the design cannot hide itself.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			seen_ff <= 1'b0;
			pcnt_ff <= 5'h00;
		end else begin
			seen_ff <= mdi_pulse_in;
			pcnt_ff <= nxt_pcnt;
		end
	end
	a_rx_neg: assert property (pulse_rx_en |-> pma_rx_en == 4'hC)
		else $error("receive switch wrong while negotiating");
	a_rx_done: assert property (!pulse_rx_en |-> $onehot(pma_rx_en))
		else $error("receive switch feeds more than one PMA");
	a_tx_neg: assert property (pulse_rx_en |-> !mdi_tx)
		else $error("PMA data reaches the line while negotiating");
	a_tx_pma: assert property (!pulse_rx_en |-> mdi_tx == |(pma_tx & pma_rx_en))
		else $error("line not driven by the chosen PMA");
	a_burst_off: assert property (!pulse_rx_en |-> !mdi_pulse_out)
		else $error("pulse burst after completion");
	a_able_min: assert property ($rose(partner_able) |-> pcnt_ff >= 5'h06)
		else $error("partner capable after too few pulses");
	a_able_max: assert property (pcnt_ff == 5'h11 |-> ##[0:8] partner_able)
		else $error("partner not capable after seventeen pulses");
	a_apb_ready: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("slave error outside an access phase");
endmodule : tpan_link_props

bind tpan_link tpan_link_props u_props (.sys_clk(sys_clk), .rst(rst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .mdi_pulse_in(mdi_pulse_in),
	.mdi_pulse_out(mdi_pulse_out), .pma_tx(pma_tx), .mdi_tx(mdi_tx),
	.pma_rx_en(pma_rx_en), .pulse_rx_en(pulse_rx_en), .partner_able(partner_able));

// ### verification/tpan_partner_model.sv
// Link partner model: sends one pulse burst that carries a 16-bit word.
// Assumes its own free-running time base on lnk_clk; the line idles low.
`timescale 1ns/1ns
module tpan_partner_model #(
	parameter int CLK_GAP  = 500,   // Link cycles between clock pulses.
	parameter int DATA_OFS = 250    // Link cycles from clock to data slot.
) (
	input  wire logic        lnk_clk,
	input  wire logic        start,
	input  wire logic [15:0] word,
	output logic             pulse,
	output logic             busy
);
	int i;   // Clock position within the burst.
	// One burst per start; gaps exceed the longest data window, so a
	// missing data pulse must be read as a zero.
	initial begin
		pulse = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge lnk_clk);
			if (start && !busy) begin
				busy <= 1'b1;
				for (i = 0; i < 17; i++) begin
					pulse <= 1'b1;
					@(posedge lnk_clk);
					pulse <= 1'b0;
					if (i == 16) break;
					repeat (DATA_OFS - 1) @(posedge lnk_clk);
					pulse <= word[i];
					@(posedge lnk_clk);
					pulse <= 1'b0;
					repeat (CLK_GAP - DATA_OFS - 1) @(posedge lnk_clk);
				end
				busy <= 1'b0;
				wait (!start);
			end
		end
	end
endmodule : tpan_partner_model

// ### verification/tpan_link_tb_top.sv
// Self-checking bench for the negotiation pulse link.
// Assumes the partner model drives the medium pulse input.
`timescale 1ns/1ns
module tpan_link_tb_top
	import tpan_pkg::*;
;
	typedef struct packed { logic wr; logic err; logic [31:0] d; } tpan_exp_type;
	logic             sys_clk, rst, lnk_clk, start, busy;
	logic             psel, penable, pwrite, pready, pslverr;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata;
	logic [PMA_N-1:0] pma_tx, pma_rx_en;
	logic             mdi_pulse_in, mdi_pulse_out, mdi_tx, pulse_rx_en;
	logic             partner_able, complete_ack;
	tpan_match_type   match;
	logic [15:0]      word;           // Word the partner sends.
	int               bad_count, n_compared, seed, h;
	tpan_exp_type     exp_q[$];       // Noted results, oldest first.
	tpan_exp_type     got_e;
	//****************
	// Clocks and parts.
	//****************
	initial sys_clk = 1'b0;
	initial lnk_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;
	always #80 lnk_clk = ~lnk_clk;
	tpan_link dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mdi_pulse_in(mdi_pulse_in), .mdi_pulse_out(mdi_pulse_out),
		.pma_tx(pma_tx), .mdi_tx(mdi_tx), .pma_rx_en(pma_rx_en), .pulse_rx_en(pulse_rx_en),
		.partner_able(partner_able), .complete_ack(complete_ack), .match(match));
	tpan_partner_model peer (.lnk_clk(lnk_clk), .start(start), .word(word),
		.pulse(mdi_pulse_in), .busy(busy));
	task automatic cmp(input logic [31:0] got, input logic [31:0] e, input string what);
		n_compared++;
		if (got !== e) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, e);
		end
	endtask : cmp
	// One APB transfer; the request holds until ready is seen high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic err);
		exp_q.push_back('{wr, err, e});
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees ready.
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic results;
		if (exp_q.size() != 0) bad_count++;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// The watcher takes the oldest note at each completed transfer.
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) begin
			got_e = exp_q.pop_front();
			cmp(pslverr, got_e.err, "slave error");
			if (!got_e.wr) cmp(prdata, got_e.d, "read data");
		end
	end
	// A full burst takes some 128k cycles, hence the long limit.
	initial begin
		repeat (200000) @(posedge sys_clk);
		bad_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		results();
	end
	initial begin
		seed = 27;
		bad_count = 0;
		n_compared = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pma_tx = 4'h0;
		start = 1'b0;
		word = 16'h0000;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		apb(1'b0, 8'h00, 32'h0000_0000, 32'h0000_0000, 1'b0);
		apb(1'b0, 8'h04, 32'h0000_0000, 32'h0000_0021, 1'b0);
		apb(1'b0, 8'h08, 32'h0000_0000, 32'h0000_0000, 1'b0);
		apb(1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000, 1'b0);
		apb(1'b0, 8'h14, 32'h0000_0000, 32'h0000_0000, 1'b1);
		$display("test reset_values done");
		// Undefined selector, unsupported abilities and NP without next-page wish.
		apb(1'b1, 8'h04, 32'h0000_9FFE, 32'h0000_0000, 1'b0);
		apb(1'b0, 8'h04, 32'h0000_0000, 32'h0000_01E1, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0002, 32'h0000_0000, 1'b0);
		apb(1'b0, 8'h04, 32'h0000_0000, 32'h0000_81E1, 1'b0);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
		apb(1'b0, 8'h00, 32'h0000_0000, 32'h0000_0002, 1'b0);
		$display("test advertised_word done");
		for (h = 0; h < 4; h++) begin
			pma_tx <= 4'($random(seed));
			apb(1'b1, 8'h00, 32'h0000_0004 | (h << 4), 32'h0000_0000, 1'b0);
			repeat (2) @(posedge sys_clk);
			cmp(pma_rx_en, 32'h0000_0001 << h, "receive switch");
			cmp(pulse_rx_en, 32'h0000_0000, "pulse receivers");
			cmp(mdi_tx, pma_tx[h], "transmit switch");
		end
		apb(1'b1, 8'h00, 32'h0000_0001, 32'h0000_0000, 1'b0);
		repeat (2) @(posedge sys_clk);
		cmp(pma_rx_en, 32'h0000_000C, "receive switch");
		cmp(pulse_rx_en, 32'h0000_0001, "pulse receivers");
		cmp(mdi_tx, 32'h0000_0000, "transmit switch");
		$display("test switches done");
		// D0 set and D15 clear, so a reversed order cannot pass.
		word <= (16'($random(seed)) | 16'h0001) & 16'h7FFF;
		start <= 1'b1;
		repeat (200) @(posedge sys_clk);
		start <= 1'b0;
		while (busy !== 1'b0) begin
			@(posedge sys_clk);
		end
		// The word is handed over only after the line stays quiet for the longest gap.
		repeat (17000) @(posedge sys_clk);
		cmp(partner_able, 32'h0000_0001, "partner capable");
		apb(1'b0, 8'h08, 32'h0000_0000, {16'h0000, word}, 1'b0);
		apb(1'b0, 8'h10, 32'h0000_0000, 32'h0000_0001, 1'b0);
		@(posedge sys_clk);
		$display("test receive_burst done");
		results();
	end
endmodule : tpan_link_tb_top
